// >>> rtl/hotplug_slot_regs.svh
/*
 * constants for the hot-plug slot control/status word: offset, field positions,
 * reset values and indicator encodings.
 * assumes inclusion by bare name from the design module, the checker and the bench.
 */
`ifndef HOTPLUG_SLOT_REGS_SVH
`define HOTPLUG_SLOT_REGS_SVH

`define HP_SLOT_OFFSET        8'hD8
`define HP_CTL_ABP_EN_BIT     0
`define HP_CTL_PF_EN_BIT      1
`define HP_CTL_PDC_EN_BIT     3
`define HP_CTL_CC_EN_BIT      4
`define HP_CTL_HPIE_BIT       5
`define HP_CTL_ATTN_LSB       6
`define HP_CTL_PWRIND_LSB     8
`define HP_CTL_PWR_OFF_BIT    10
`define HP_CTL_DLLSC_EN_BIT   12
`define HP_STS_ABP_BIT        16
`define HP_STS_PF_BIT         17
`define HP_STS_LATCH_CHG_BIT  18
`define HP_STS_PDC_BIT        19
`define HP_STS_CC_BIT         20
`define HP_STS_LATCH_BIT      21
`define HP_STS_PRESENT_BIT    22
`define HP_STS_DLLSC_BIT      24
`define HP_IND_RESET          2'h3
`define HP_IND_ON             2'h1
`define HP_IND_BLINK          2'h2
`define HP_IND_OFF            2'h3

`endif

// >>> rtl/hotplug_slot_pkg.sv
/*
 * types shared by the hot-plug slot register block.
 * assumes the constants header is on the include path.
 */
package hotplug_slot_pkg;
   // attention message sent on every write; power message only if no write follows in the next cycle
   typedef struct packed {
      logic       valid;
      logic       is_power;   // 0: attention indicator, 1: power indicator
      logic [1:0] state;      // on, blink or off code as written
   } indicator_msg_t;
endpackage

// >>> rtl/hotplug_slot_control_status.sv
/*
 * hot-plug slot control and status register word for one downstream port.
 * assumes a simple register port on the core clock; slot sensor pins are
 * asynchronous and are synchronised here; link_active comes from core logic.
 */
// Decided for this implementation: the strobed register port.
// Overview of operation
// - control bit 0 enables event on attention button press.
// - control bit 1 enables event on power fault.
// - control bit 3 enables event on card presence change.
// - control bit 4 enables interrupt on command complete, never wakeup.
// - control bit 5 gates all hot-plug interrupts.
// - attention indicator field 7:6, on/blink/off codes, resets to off.
// - each attention field write sends an attention indicator message.
// - power indicator field 9:8, on/blink/off codes, resets to off.
// - each power field write not followed by a write in the next cycle sends a power indicator message.
// - control bit 10 commands slot power, one means off, resets zero.
// - control bit 12 enables notice on link-active change if supported.
// - status bit 16 latches button press, write one clears.
// - status bit 17 latches power fault, write one clears.
// - status bit 18 reports latch sensor change, read-only.
// - status bit 19 latches presence change, write one clears.
// - status bit 20 latches command completion, write one clears.
// - status bit 21 reads latch sensor live, one means open.
// - status bit 22 reads card presence.
// - with no slot implemented, presence bit reads one.
// - presence bit resets to inverted presence strap.
// - status bit 24 latches link-active changes, write one clears.
`timescale 1ns/1ns
`include "hotplug_slot_regs.svh"

module hotplug_slot_control_status
   import hotplug_slot_pkg::*;
#(
   parameter bit DLLSC_SUPPORTED = 1'b1
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic [7:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [31:0]          rdata,
   input  wire logic                 slot_implemented,
   input  wire logic                 card_present_strap,
   input  wire logic                 attn_button_pin,
   input  wire logic                 power_fault_pin,
   input  wire logic                 retention_latch,
   input  wire logic                 card_present_pin,
   input  wire logic                 cmd_done,
   input  wire logic                 link_active,
   output logic                      hp_irq,
   output logic                      hp_wake,
   output logic                      slot_power_off,
   output logic      [1:0]           attn_ind,
   output logic      [1:0]           power_ind,
   output indicator_msg_t            ind_msg
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts when stage 2 and 3 agree
   logic [3:0] s1_q;
   logic [3:0] s2_q;
   logic [3:0] s3_q;
   logic [3:0] stable_q;

   // order: button, fault, latch, presence; stage 1 feeds only stage 2
   always_ff @(posedge clock) begin
      s1_q <= {card_present_pin, retention_latch, power_fault_pin, attn_button_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   wire [3:0] agree = ~(s2_q ^ s3_q);
   wire [3:0] stable_d = (agree & s3_q) | (~agree & stable_q);
   wire [3:0] rise = stable_d & ~stable_q;
   wire [3:0] chg  = stable_d ^ stable_q;

   ////////////////////////////////////////////////////////////////////////////
   // register port decode
   wire hit   = (addr == `HP_SLOT_OFFSET);
   wire wr_hit = wr & hit;

   function automatic logic w1c(input logic cur, input logic set, input logic clr);
      // a set in the same cycle as the clear wins
      return set | (cur & ~clr);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // control fields
   logic       en_abp_q, en_pf_q, en_pdc_q, en_cc_q, hpie_q, en_dllsc_q, pwr_off_q;
   logic [1:0] attn_q, pind_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         en_abp_q   <= 1'b0;
         en_pf_q    <= 1'b0;
         en_pdc_q   <= 1'b0;
         en_cc_q    <= 1'b0;
         hpie_q     <= 1'b0;
         en_dllsc_q <= 1'b0;
         pwr_off_q  <= 1'b0;
         attn_q     <= `HP_IND_RESET;
         pind_q     <= `HP_IND_RESET;
      end else if (wr_hit) begin
         en_abp_q   <= wdata[`HP_CTL_ABP_EN_BIT];
         en_pf_q    <= wdata[`HP_CTL_PF_EN_BIT];
         en_pdc_q   <= wdata[`HP_CTL_PDC_EN_BIT];
         en_cc_q    <= wdata[`HP_CTL_CC_EN_BIT];
         hpie_q     <= wdata[`HP_CTL_HPIE_BIT];
         attn_q     <= wdata[`HP_CTL_ATTN_LSB +: 2];
         pind_q     <= wdata[`HP_CTL_PWRIND_LSB +: 2];
         pwr_off_q  <= wdata[`HP_CTL_PWR_OFF_BIT];
         en_dllsc_q <= wdata[`HP_CTL_DLLSC_EN_BIT] & DLLSC_SUPPORTED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags and live state
   logic sts_abp_q, sts_pf_q, sts_latch_chg_q, sts_pdc_q, sts_cc_q, sts_dllsc_q;
   logic link_q, present_q, strap_done_q;

   wire clr_abp   = wr_hit & wdata[`HP_STS_ABP_BIT];
   wire clr_pf    = wr_hit & wdata[`HP_STS_PF_BIT];
   wire clr_pdc   = wr_hit & wdata[`HP_STS_PDC_BIT];
   wire clr_cc    = wr_hit & wdata[`HP_STS_CC_BIT];
   wire clr_dllsc = wr_hit & wdata[`HP_STS_DLLSC_BIT];
   wire link_chg  = link_active ^ link_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         // follow the pins through reset so release shows no false edge
         stable_q        <= s3_q;
         sts_abp_q       <= 1'b0;
         sts_pf_q        <= 1'b0;
         sts_latch_chg_q <= 1'b0;
         sts_pdc_q       <= 1'b0;
         sts_cc_q        <= 1'b0;
         sts_dllsc_q     <= 1'b0;
         link_q          <= 1'b0;
         strap_done_q    <= 1'b0;
         present_q       <= ~card_present_strap;
      end else begin
         stable_q        <= stable_d;
         link_q          <= link_active;
         strap_done_q    <= 1'b1;
         sts_abp_q       <= w1c(sts_abp_q, rise[0], clr_abp);
         sts_pf_q        <= w1c(sts_pf_q, rise[1], clr_pf);
         sts_latch_chg_q <= sts_latch_chg_q | chg[2];
         sts_pdc_q       <= w1c(sts_pdc_q, chg[3], clr_pdc);
         sts_cc_q        <= w1c(sts_cc_q, cmd_done, clr_cc);
         sts_dllsc_q     <= w1c(sts_dllsc_q, link_chg, clr_dllsc);
         // strap caught after release, then presence tracks the pin
         present_q <= strap_done_q ? stable_d[3] : ~card_present_strap;
      end
   end

   // link_q starts at zero so a link already up at release counts as a change
   wire present_rd = ~slot_implemented | present_q;

   wire [31:0] word = {7'h00,
                       sts_dllsc_q, 1'b0, present_rd,
                       stable_q[2],
                       sts_cc_q, sts_pdc_q, sts_latch_chg_q, sts_pf_q, sts_abp_q,
                       3'h0, en_dllsc_q, 1'b0, pwr_off_q, pind_q, attn_q,
                       hpie_q, en_cc_q, en_pdc_q, 1'b0, en_pf_q, en_abp_q};

   ////////////////////////////////////////////////////////////////////////////
   // interrupt and wakeup; command complete raises no wakeup
   wire ev_any  = (sts_abp_q & en_abp_q) | (sts_pf_q & en_pf_q) | (sts_pdc_q & en_pdc_q);
   wire irq_d   = hpie_q & (ev_any | (sts_cc_q & en_cc_q)
                  | (sts_dllsc_q & en_dllsc_q));
   wire wake_d  = ev_any | (sts_dllsc_q & en_dllsc_q);

   // power message held one cycle behind the attention message
   logic       pend_q;
   logic [1:0] pend_state_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         pend_q       <= 1'b0;
         pend_state_q <= `HP_IND_RESET;
      end else begin
         pend_q       <= wr_hit;
         pend_state_q <= wr_hit ? wdata[`HP_CTL_PWRIND_LSB +: 2] : pend_state_q;
      end
   end

   // outputs registered; message pulses for attention, then power unless a write follows
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata          <= 32'h0000_0000;
         hp_irq         <= 1'b0;
         hp_wake        <= 1'b0;
         slot_power_off <= 1'b0;
         attn_ind       <= `HP_IND_RESET;
         power_ind      <= `HP_IND_RESET;
         ind_msg        <= '0;
      end else begin
         rdata          <= (rd & hit) ? word : 32'h0000_0000;
         hp_irq         <= irq_d;
         hp_wake        <= wake_d;
         slot_power_off <= pwr_off_q;
         attn_ind       <= attn_q;
         power_ind      <= pind_q;
         ind_msg        <= '0;
         if (wr_hit) begin
            // both fields are written together; attention goes out first and
            // the power message follows in the next cycle if no write comes then
            ind_msg <= '{valid: 1'b1, is_power: 1'b0,
                         state: wdata[`HP_CTL_ATTN_LSB +: 2]};
         end else if (pend_q) begin
            ind_msg <= '{valid: 1'b1, is_power: 1'b1, state: pend_state_q};
         end
      end
   end

endmodule

// >>> test/hotplug_slot_assertions.sv
/* checker for the slot control/status word, seeing only top ports.
   assumes a bind from the bench top file and a single core clock. */
`timescale 1ns/1ns
`include "hotplug_slot_regs.svh"
module hotplug_slot_assertions
   import hotplug_slot_pkg::*;
(
   input wire logic           clock,
   input wire logic           rst,
   input wire logic [7:0]     addr,
   input wire logic [31:0]    wdata,
   input wire logic           wr,
   input wire logic           rd,
   input wire logic [31:0]    rdata,
   input wire logic           slot_implemented,
   input wire logic           retention_latch,
   input wire logic           hp_irq,
   input wire logic           slot_power_off,
   input wire logic [1:0]     attn_ind,
   input wire logic [1:0]     power_ind,
   input wire indicator_msg_t ind_msg
);
   // one clock domain, quiet through reset
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire logic hit_wr = wr && addr == `HP_SLOT_OFFSET;
   wire logic hit_rd = rd && addr == `HP_SLOT_OFFSET;
   logic      gate_q;
   // shadow of the gate bit, since the word itself is not on a port
   always_ff @(posedge clock) begin
      gate_q <= rst ? 1'b0 : (hit_wr ? wdata[`HP_CTL_HPIE_BIT] : gate_q);
   end
   sequence lone_wr_s; hit_wr ##1 !hit_wr; endsequence
   sequence calm_rd_s; $stable(retention_latch) [*5] ##0 hit_rd; endsequence
   ////////////////////////////////////////////////////////////////////////////
   reset_out_a: assert property (
      $fell(rst) |-> attn_ind == 2'h3 && power_ind == 2'h3 && !slot_power_off)
      else $error("outputs off reset value");
   attn_fld_a: assert property (
      hit_wr |=> ##1 attn_ind == $past(wdata[7:6], 2)) else $error("attention field");
   pwr_fld_a: assert property (
      hit_wr |=> ##1 power_ind == $past(wdata[9:8], 2)) else $error("power field");
   power_ctl_a: assert property (
      hit_wr |=> ##1 slot_power_off == $past(wdata[10], 2)) else $error("slot power");
   attn_msg_a: assert property (
      hit_wr |=> ind_msg.valid && !ind_msg.is_power && ind_msg.state == $past(wdata[7:6]))
      else $error("attention message");
   pwr_msg_a: assert property (
      lone_wr_s |=> ind_msg.valid && ind_msg.is_power && ind_msg.state == $past(wdata[9:8], 2))
      else $error("power message");
   gate_irq_a: assert property (
      !gate_q |=> !hp_irq) else $error("interrupt with gate clear");
   rsvd_zero_a: assert property (
      (rdata & 32'hFE80_E804) == 32'h0) else $error("reserved bit set");
   no_slot_a: assert property (
      hit_rd && !slot_implemented |=> rdata[22]) else $error("presence without slot");
   latch_live_a: assert property (
      calm_rd_s |=> rdata[21] == $past(retention_latch)) else $error("latch state");
endmodule

// >>> test/hotplug_slot_model.sv
/* slot model: card, retention latch, button and fault sensor.
   assumes the bench calls burst to make slot events. */
`timescale 1ns/1ns
module hotplug_slot_model (
   input  wire logic clock,
   output logic      attn_button_pin,
   output logic      power_fault_pin,
   output logic      retention_latch,
   output logic      card_present_pin
);
   // card seated with the latch closed
   initial begin
      attn_button_pin = 1'b0;
      power_fault_pin = 1'b0;
      retention_latch = 1'b0;
      card_present_pin = 1'b1;
   end
   // pulses held four cycles, long enough to pass the pin synchroniser
   task burst(input logic latch_open, input logic card_in);
      @(posedge clock);
      attn_button_pin <= 1'b1;
      power_fault_pin <= 1'b1;
      retention_latch <= latch_open;
      card_present_pin <= card_in;
      repeat (4) @(posedge clock);
      attn_button_pin <= 1'b0;
      power_fault_pin <= 1'b0;
   endtask
endmodule

// >>> test/hotplug_slot_control_status_tb.sv
/* bench for the slot word: register port, slot model, event pins.
   assumes 25 MHz core clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`include "hotplug_slot_regs.svh"
module hotplug_slot_control_status_tb
   import hotplug_slot_pkg::*;
;
   logic clock = 0, rst = 1, wr = 0, rd = 0, rd_seen = 0, cmd_done = 0, link_active = 0;
   logic slot_implemented = 1, card_present_strap = 0, hp_irq, hp_wake, slot_power_off;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d, seed = 32'h0001_675B;
   logic [1:0] attn_ind, power_ind;
   logic [63:0] e;
   logic [63:0] rd_q[$];
   logic [2:0] msg_q[$];
   indicator_msg_t ind_msg;
   wire logic btn, flt, latch, card;
   int n_errors = 0, checks = 0;
   always #20 clock = ~clock;
   hotplug_slot_control_status i_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .slot_implemented(slot_implemented),
      .card_present_strap(card_present_strap), .attn_button_pin(btn), .power_fault_pin(flt),
      .retention_latch(latch), .card_present_pin(card), .cmd_done(cmd_done),
      .link_active(link_active), .hp_irq(hp_irq), .hp_wake(hp_wake),
      .slot_power_off(slot_power_off), .attn_ind(attn_ind), .power_ind(power_ind),
      .ind_msg(ind_msg));
   hotplug_slot_model i_slot (.clock(clock), .attn_button_pin(btn), .power_fault_pin(flt),
      .retention_latch(latch), .card_present_pin(card));
   ////////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // a write to the word queues both indicator messages it must send
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      wr <= 1'b1; addr <= a; wdata <= v;
      if (a == `HP_SLOT_OFFSET) begin
         msg_q.push_back({1'b0, v[7:6]});
         msg_q.push_back({1'b1, v[9:8]});
      end
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      @(posedge clock);
      rd <= 1'b1; addr <= a; rd_q.push_back({m, x});
      @(posedge clock);
      rd <= 1'b0;
   endtask
   task pulse_wait(input logic c, input logic l);
      @(posedge clock);
      cmd_done <= c; link_active <= l;
      @(posedge clock);
      cmd_done <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   // watcher: read data one cycle after the strobe, messages as they appear
   always @(posedge clock) begin
      if (rd_seen) begin
         e = rd_q.pop_front();
         chk("rdata", rdata & e[63:32], e[31:0]);
      end
      if (ind_msg.valid === 1'b1) chk("ind_msg", {29'h0, ind_msg[2:0]}, {29'h0, msg_q.pop_front()});
      rd_seen <= rd;
   end
   // the main sequence, with pins allowed to settle after reset first
   initial begin
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      rd_reg(8'hD8, 32'hFFFF_FFFF, 32'h0040_03C0);
      wr_reg(8'hD8, 32'hFFFF_03C0);
      repeat (4) begin
         d = rnd();
         wr_reg(8'hD8, {16'h0, d[15:0]});
         rd_reg(8'hD8, 32'hFFFF_FFFF, {16'h0040, d[15:0] & 16'h17FB});
      end
      wr_reg(8'hD4, 32'hFFFF_FFFF);
      rd_reg(8'hD4, 32'hFFFF_FFFF, 32'h0);
      rd_reg(8'hD8, 32'hFFFF_FFFF, {16'h0040, d[15:0] & 16'h17FB});
      wr_reg(8'hD8, 32'h0000_13FB);
      i_slot.burst(1'b1, 1'b0);
      pulse_wait(1'b1, 1'b1);
      chk("hp_irq", {31'h0, hp_irq}, 32'h1);
      chk("hp_wake", {31'h0, hp_wake}, 32'h1);
      rd_reg(8'hD8, 32'hFFFF_FFFF, 32'h013F_13FB);
      wr_reg(8'hD8, 32'hFFFF_13DB);
      rd_reg(8'hD8, 32'hFFFF_FFFF, 32'h0024_13DB);
      pulse_wait(1'b1, 1'b1);
      chk("hp_irq", {31'h0, hp_irq}, 32'h0);
      wr_reg(8'hD8, 32'h0000_13FB);
      repeat (4) @(posedge clock);
      chk("hp_irq", {31'h0, hp_irq}, 32'h1);
      chk("hp_wake", {31'h0, hp_wake}, 32'h0);
      wr_reg(8'hD8, 32'h0010_13FB);
      repeat (4) @(posedge clock);
      chk("hp_irq", {31'h0, hp_irq}, 32'h0);
      slot_implemented <= 1'b0;
      rd_reg(8'hD8, 32'h0040_0000, 32'h0040_0000);
      repeat (2) @(posedge clock);
      close_out;
   end
   // cut a hang short
   initial begin
      repeat (2000) @(posedge clock);
      n_errors++;
      close_out;
   end
endmodule
bind hotplug_slot_control_status hotplug_slot_assertions i_chk (.clock(clock), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .slot_implemented(slot_implemented), .retention_latch(retention_latch), .hp_irq(hp_irq),
   .slot_power_off(slot_power_off), .attn_ind(attn_ind), .power_ind(power_ind),
   .ind_msg(ind_msg));
